// ==== fclcb_bank.sv ====
`timescale 1ns/10ps
// Function
// RULE_01 - Deceleration code used only with surge protection off and source select zero.
// RULE_02 - Source select one makes deceleration follow the acceleration rate code.
// RULE_03 - Deceleration code is bits 23:19; all-ones code means no limit.
// RULE_04 - PWM frequency bits 18:15, 10 kHz plus 5 kHz per code to Ah.
// RULE_05 - Bit 14 picks continuous or discontinuous space vector modulation.
// RULE_06 - Pulse select bits 13:12: both loops, closed only, or first-run open.
// RULE_07 - Pulse divider bits 11:8 divides by code; zero and one divide by one.
// RULE_08 - Bit 7 stops pulses once back-EMF falls below threshold.
// RULE_09 - Back-EMF threshold bits 6:4, codes 0 to 5 valid.
// RULE_10 - Bit 3 enables surge protection.
// RULE_11 - Bit 2 enables dead-time compensation.
// RULE_12 - Bit 1 disables speed loop, entering torque mode.
// RULE_13 - Second settings word sits at 8Ah and resets to zero.
// RULE_14 - Reserved bit 0 is stored but steers nothing.
module fclcb_bank
   import fclcb_pkg::*;
(
   input wire logic mclk_i, // 20 MHz clock
   input wire logic sys_rst_i, // Synchronous reset, high
   input wire logic [7:0] reg_addr_i, // Register byte offset
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   input wire logic [31:0] reg_wdata_i, // Write data
   output logic [31:0] reg_rdata_o, // Read data, registered
   output logic reg_hit_o, // Last read hit a register
   output fclcb_cfg_t cfg_o, // Decoded settings
   output logic [31:0] settings_two_o // Second settings word
);

   fclcb_state_t s_q;
   fclcb_state_t s_d;

   // Which settings word an offset selects
   typedef enum logic [1:0] {
      FCLCB_SEL_NONE,
      FCLCB_SEL_ONE,
      FCLCB_SEL_TWO
   } fclcb_word_sel_t;

   // ----------------------------------------
   // Address and read helpers
   // ----------------------------------------

   function automatic fclcb_word_sel_t fclcb_word_sel(input logic [7:0] addr);
      fclcb_word_sel_t sel;
      sel = FCLCB_SEL_NONE;
      if (addr == FCLCB_OFS_SETTINGS_ONE) begin
         sel = FCLCB_SEL_ONE;
      end
      // RULE_13 second word offset
      if (addr == FCLCB_OFS_SETTINGS_TWO) begin
         sel = FCLCB_SEL_TWO;
      end
      return sel;
   endfunction

   // Unmapped reads return zero with no hit, so software sees a clean value
   function automatic logic [32:0] fclcb_read_mux(input fclcb_word_sel_t sel,
      input fclcb_state_t s);
      logic [32:0] r;
      r = {1'b0, 32'h0000_0000};
      case (sel)
         FCLCB_SEL_ONE: begin
            r = {1'b1, s.settings_one};
         end
         FCLCB_SEL_TWO: begin
            r = {1'b1, s.settings_two};
         end
         default: begin
            r = {1'b0, 32'h0000_0000};
         end
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // Field helpers
   // ----------------------------------------

   // The acceleration and deceleration fields share one five-bit rate layout
   function automatic logic [4:0] fclcb_rate_field(input logic [31:0] w, input int lsb);
      return w[lsb +: 5];
   endfunction

   // RULE_02 acceleration code reuse
   function automatic logic [4:0] fclcb_decel_code(input logic [31:0] w);
      logic [4:0] code;
      code = fclcb_rate_field(w, FCLCB_ACC_LSB);
      if (!w[FCLCB_DEC_SRC_BIT]) begin
         // RULE_03 deceleration field
         code = fclcb_rate_field(w, FCLCB_DEC_LSB);
      end
      return code;
   endfunction

   // RULE_03 all-ones lifts limit
   function automatic logic fclcb_rate_unlimited(input logic [4:0] code);
      return code == FCLCB_RATE_NO_LIMIT;
   endfunction

   // RULE_01 deceleration source gating
   function automatic logic fclcb_decel_applied(input logic [31:0] w);
      // Surge protection or the source select each take the ramp-down away from this code
      return !w[FCLCB_SURGE_EN_BIT] && !w[FCLCB_DEC_SRC_BIT];
   endfunction

   // Out-of-range codes are flagged, not clipped, so a read-back still shows what was written
   function automatic logic fclcb_code_ok(input logic [3:0] code, input logic [3:0] max);
      return code <= max;
   endfunction

   // RULE_06 pulse select match
   function automatic logic fclcb_pulse_is(input logic [31:0] w, input fclcb_pulse_sel_t sel);
      // Code 3 matches neither select and leaves both flags low
      return fclcb_pulse_sel_t'(w[FCLCB_PULSE_SEL_LSB +: 2]) == sel;
   endfunction

   // RULE_07 zero divides by one
   function automatic logic [3:0] fclcb_pulse_div(input logic [3:0] code);
      logic [3:0] div;
      div = code;
      if (code == 4'h0) begin
         div = 4'h1;
      end
      return div;
   endfunction

   // ----------------------------------------
   // Field decode
   // ----------------------------------------

   // Decoded on the write and registered, so the core never sees a half-decoded word
   function automatic fclcb_cfg_t fclcb_decode(input logic [31:0] w);
      fclcb_cfg_t c;
      c = '0;
      // RULE_01 deceleration source gating
      c.decel_applied = fclcb_decel_applied(w);
      // RULE_02 reuse acceleration code
      c.decel_rate_code = fclcb_decel_code(w);
      // RULE_03 no-limit flag
      c.decel_unlimited = fclcb_rate_unlimited(c.decel_rate_code);
      // RULE_04 PWM frequency code
      c.pwm_output_frequency = w[FCLCB_PWM_FREQ_LSB +: 4];
      // Codes above Ah pass through with the valid flag low
      c.pwm_freq_valid = fclcb_code_ok(w[FCLCB_PWM_FREQ_LSB +: 4], FCLCB_PWM_FREQ_MAX);
      // RULE_05 modulation scheme
      c.pwm_discontinuous = w[FCLCB_PWM_MODE_BIT];
      // RULE_06 pulse output select
      c.speed_pulse_select = w[FCLCB_PULSE_SEL_LSB +: 2];
      c.pulse_in_open_loop = fclcb_pulse_is(w, FCLCB_PULSE_OPEN_CLOSED);
      c.pulse_first_run_only = fclcb_pulse_is(w, FCLCB_PULSE_FIRST_RUN);
      // RULE_07 divider code
      c.speed_pulse_divider = fclcb_pulse_div(w[FCLCB_PULSE_DIV_LSB +: 4]);
      // RULE_08 pulse stop mode
      c.speed_pulse_stop_config = w[FCLCB_PULSE_STOP_BIT];
      // RULE_09 back-EMF threshold
      c.pulse_stop_backemf_threshold = w[FCLCB_BACK_EMF_THR_LSB +: 3];
      // Codes 6 and 7 pass through with the valid flag low
      c.back_emf_thr_valid =
         fclcb_code_ok({1'b0, w[FCLCB_BACK_EMF_THR_LSB +: 3]}, {1'b0, FCLCB_BACK_EMF_THR_MAX});
      // RULE_10 surge protection
      c.surge_protection_enable = w[FCLCB_SURGE_EN_BIT];
      // RULE_11 dead-time compensation
      c.deadtime_comp_enable = w[FCLCB_DEADTIME_BIT];
      // RULE_12 torque mode
      c.speed_loop_disable = w[FCLCB_SPEED_DIS_BIT];
      // RULE_14 bit 0 feeds no decode
      return c;
   endfunction

   // ----------------------------------------
   // Register access
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      if (reg_wr_i) begin
         case (fclcb_word_sel(reg_addr_i))
            FCLCB_SEL_ONE: begin
               s_d.settings_one = reg_wdata_i;
               s_d.cfg = fclcb_decode(reg_wdata_i);
            end
            // RULE_13 second word write
            FCLCB_SEL_TWO: begin
               s_d.settings_two = reg_wdata_i;
            end
            default: begin
               // Unmapped writes change nothing
               s_d.settings_one = s_q.settings_one;
            end
         endcase
      end
      // A write and a read in one cycle return the old word; read data holds until the next read
      if (reg_rd_i) begin
         {s_d.hit, s_d.rdata} = fclcb_read_mux(fclcb_word_sel(reg_addr_i), s_q);
      end
   end

   // One register stage for the whole state; reads and the decode share its timing
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s_q.settings_one <= FCLCB_RST_SETTINGS_ONE;
         // RULE_13 reset to zero
         s_q.settings_two <= FCLCB_RST_SETTINGS_TWO;
         s_q.rdata <= 32'h0000_0000;
         s_q.hit <= 1'b0;
         // Keeps the decode equal to that of the reset word from the first edge
         s_q.cfg <= fclcb_decode(FCLCB_RST_SETTINGS_ONE);
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // All outputs come straight from the state register
   assign reg_rdata_o = s_q.rdata;
   assign reg_hit_o = s_q.hit;
   assign settings_two_o = s_q.settings_two;
   assign cfg_o = s_q.cfg;

endmodule

// ==== fclcb_pkg.sv ====
package fclcb_pkg;

   // ----------------------------------------
   // Register offsets and reset values
   // ----------------------------------------
   localparam logic [7:0] FCLCB_OFS_SETTINGS_ONE = 8'h88;
   localparam logic [7:0] FCLCB_OFS_SETTINGS_TWO = 8'h8A;
   localparam logic [31:0] FCLCB_RST_SETTINGS_ONE = 32'h0000_0000;
   localparam logic [31:0] FCLCB_RST_SETTINGS_TWO = 32'h0000_0000;

   // ----------------------------------------
   // Field positions in settings word one
   // ----------------------------------------
   localparam int FCLCB_ACC_LSB = 25;
   localparam int FCLCB_DEC_SRC_BIT = 24;
   localparam int FCLCB_DEC_LSB = 19;
   localparam int FCLCB_PWM_FREQ_LSB = 15;
   localparam int FCLCB_PWM_MODE_BIT = 14;
   localparam int FCLCB_PULSE_SEL_LSB = 12;
   localparam int FCLCB_PULSE_DIV_LSB = 8;
   localparam int FCLCB_PULSE_STOP_BIT = 7;
   localparam int FCLCB_BACK_EMF_THR_LSB = 4;
   localparam int FCLCB_SURGE_EN_BIT = 3;
   localparam int FCLCB_DEADTIME_BIT = 2;
   localparam int FCLCB_SPEED_DIS_BIT = 1;

   // ----------------------------------------
   // Code limits
   // ----------------------------------------
   localparam logic [4:0] FCLCB_RATE_NO_LIMIT = 5'h1F;
   localparam logic [3:0] FCLCB_PWM_FREQ_MAX = 4'hA;
   localparam logic [2:0] FCLCB_BACK_EMF_THR_MAX = 3'h5;

   typedef enum logic [1:0] {
      FCLCB_PULSE_OPEN_CLOSED,
      FCLCB_PULSE_CLOSED_ONLY,
      FCLCB_PULSE_FIRST_RUN,
      FCLCB_PULSE_NA
   } fclcb_pulse_sel_t;

   // Decoded configuration handed to the motor control core
   typedef struct packed {
      logic [4:0] decel_rate_code;
      logic decel_unlimited;
      logic decel_applied;
      logic [3:0] pwm_output_frequency;
      logic pwm_freq_valid;
      logic pwm_discontinuous;
      logic [1:0] speed_pulse_select;
      logic pulse_in_open_loop;
      logic pulse_first_run_only;
      logic [3:0] speed_pulse_divider;
      logic speed_pulse_stop_config;
      logic [2:0] pulse_stop_backemf_threshold;
      logic back_emf_thr_valid;
      logic surge_protection_enable;
      logic deadtime_comp_enable;
      logic speed_loop_disable;
   } fclcb_cfg_t;

   typedef struct packed {
      logic [31:0] settings_one;
      logic [31:0] settings_two;
      logic [31:0] rdata;
      logic hit;
      fclcb_cfg_t cfg;
   } fclcb_state_t;

endpackage

// ==== fclcb_bank_checker.sv ====
`timescale 1ns/10ps
module fclcb_bank_checker
   import fclcb_pkg::*;
(
   input wire logic mclk_i, // Clock
   input wire logic sys_rst_i, // Reset
   input wire logic [7:0] reg_addr_i, // Offset
   input wire logic reg_wr_i, // Write
   input wire logic reg_rd_i, // Read
   input wire logic [31:0] reg_wdata_i, // Wdata
   input wire logic [31:0] reg_rdata_o, // Rdata
   input wire logic reg_hit_o, // Hit
   input fclcb_cfg_t cfg_o, // Decode
   input wire logic [31:0] settings_two_o // Word two
);
   logic [31:0] d_q;
   wire w1 = reg_wr_i && reg_addr_i == FCLCB_OFS_SETTINGS_ONE;
   wire w2 = reg_wr_i && reg_addr_i == FCLCB_OFS_SETTINGS_TWO;
   // Write data one cycle late, to compare against the decode it caused
   always_ff @(posedge mclk_i) d_q <= reg_wdata_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   a_decel_gate: assert property (w1 |=>
      cfg_o.decel_applied == !(d_q[3] || d_q[24])) else $error("decel gate");
   a_decel_source: assert property (w1 && reg_wdata_i[24] |=>
      cfg_o.decel_rate_code == d_q[29:25]) else $error("decel source");
   a_decel_code: assert property (w1 && !reg_wdata_i[24] |=>
      cfg_o.decel_rate_code == d_q[23:19] && cfg_o.decel_unlimited == (&d_q[23:19]))
      else $error("decel code");
   a_pwm_freq: assert property (w1 |=>
      cfg_o.pwm_output_frequency == d_q[18:15] && cfg_o.pwm_freq_valid == (d_q[18:15] <= 4'hA))
      else $error("pwm freq");
   a_mode_select: assert property (w1 |=>
      {cfg_o.pwm_discontinuous, cfg_o.speed_pulse_select} == d_q[14:12]) else $error("mode");
   a_pulse_div: assert property (w1 |=>
      cfg_o.speed_pulse_divider == (d_q[11:8] == 4'h0 ? 4'h1 : d_q[11:8])
      && cfg_o.speed_pulse_stop_config == d_q[7]) else $error("pulse div");
   a_back_emf_thr: assert property (w1 |=>
      cfg_o.pulse_stop_backemf_threshold == d_q[6:4] && cfg_o.back_emf_thr_valid == (d_q[6:4] <= 3'h5))
      else $error("back_emf thr");
   a_enable_bits: assert property (w1 |=>
      {cfg_o.surge_protection_enable, cfg_o.deadtime_comp_enable, cfg_o.speed_loop_disable}
      == d_q[3:1]) else $error("enables");
   a_word_two: assert property (w2 |=> settings_two_o == d_q) else $error("word two");
   c_write_read: cover property (w1 ##1 reg_rd_i);
   c_word_two: cover property (w2);
   c_unmapped: cover property (reg_rd_i && reg_addr_i == 8'h8C);
endmodule
bind fclcb_bank fclcb_bank_checker i_fclcb_bank_checker (.mclk_i(mclk_i),
   .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .cfg_o(cfg_o),
   .settings_two_o(settings_two_o));

// ==== fclcb_bank_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
   $display("unexpected %0t %h %h", $time, a, e); end end
module fclcb_bank_tb;
   import fclcb_pkg::*;
   logic mclk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, reg_hit_o;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, settings_two_o, w;
   fclcb_cfg_t cfg_o, prev;
   int n_errors = 0, checked = 0;
   logic [31:0] tbl [5] = '{32'h00F8_0000, 32'hFFFF_FFFE, 32'h0305_1058, 32'h0005_A000,
      32'h0000_0162};
   fclcb_bank i_fclcb_bank (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .cfg_o(cfg_o),
      .settings_two_o(settings_two_o));
   initial forever #25 mclk_i = ~mclk_i;
   // One-cycle strobe; the answer is settled by the next falling edge
   task automatic op(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(negedge mclk_i);
      reg_wr_i = wr;
      reg_rd_i = !wr;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge mclk_i);
      reg_wr_i = 0;
      reg_rd_i = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic h);
      op(0, a, 32'h0);
      `CHK({reg_hit_o, reg_rdata_o}, {h, e})
   endtask
   task automatic complete_run();
      $display("errors %0d checked %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge mclk_i);
      sys_rst_i = 0;
      rd(FCLCB_OFS_SETTINGS_ONE, 32'h0, 1);
      rd(FCLCB_OFS_SETTINGS_TWO, 32'h0, 1);
      rd(8'h8C, 32'h0, 0);
      `CHK(cfg_o.speed_pulse_divider, 4'h1)
      foreach (tbl[i]) begin
         w = tbl[i];
         op(1, FCLCB_OFS_SETTINGS_ONE, w);
         `CHK(cfg_o.decel_applied, !(w[3] || w[24]))
         `CHK(cfg_o.decel_rate_code, w[24] ? w[29:25] : w[23:19])
         `CHK(cfg_o.decel_unlimited, &(w[24] ? w[29:25] : w[23:19]))
         `CHK(cfg_o.pwm_freq_valid, w[18:15] <= 4'hA)
         `CHK({cfg_o.pwm_discontinuous, cfg_o.speed_pulse_select}, w[14:12])
         `CHK(cfg_o.speed_pulse_divider, w[11:8] == 4'h0 ? 4'h1 : w[11:8])
         `CHK(cfg_o.back_emf_thr_valid, w[6:4] <= 3'h5)
         `CHK(cfg_o.speed_loop_disable, w[1])
         `CHK(cfg_o.pwm_output_frequency, w[18:15])
         `CHK(cfg_o.pulse_in_open_loop, w[13:12] == 2'h0)
         `CHK(cfg_o.pulse_first_run_only, w[13:12] == 2'h2)
         `CHK(cfg_o.speed_pulse_stop_config, w[7])
         `CHK(cfg_o.pulse_stop_backemf_threshold, w[6:4])
         `CHK({cfg_o.surge_protection_enable, cfg_o.deadtime_comp_enable}, w[3:2])
         rd(FCLCB_OFS_SETTINGS_ONE, w, 1);
         prev = cfg_o;
         op(1, FCLCB_OFS_SETTINGS_ONE, w ^ 32'h1);
         `CHK(cfg_o, prev)
      end
      op(1, FCLCB_OFS_SETTINGS_TWO, 32'hA5C3_0F96);
      op(1, 8'h8C, 32'h0);
      rd(FCLCB_OFS_SETTINGS_ONE, tbl[4] ^ 32'h1, 1);
      `CHK(settings_two_o, 32'hA5C3_0F96)
      rd(FCLCB_OFS_SETTINGS_TWO, 32'hA5C3_0F96, 1);
      complete_run();
   end
endmodule
